// ===== hcu_hyp_config.sv
// Hypervisor configuration upper control bits with APB access and effective values
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - World select 0 makes these controls act as zero except on direct access.
// - Host mode with general trap ignores mismatch and both stage 2 no-cache bits.
// - Bit 38 may read zero; when 1 mismatched cacheability may lose coherency.
// - Ordering region trap sends unsecured kernel ordering register accesses to hypervisor.
// - General trap set ignores ordering trap, memory read trap, hypercall disable.
// - Bit 34 selects hypervisor or host operating system role; may be cached.
// - Bit 33 with stage 2 on forces instruction stage 2 to non-cacheable.
// - Bit 32 with stage 2 on forces data and walks stage 2 non-cacheable.
// - Stage 2 no-cache bits never affect hypervisor or monitor regimes.
// - Bit 31 selects 32 or 64-bit lower levels; reads one if 32 impossible.
// - World select 0 makes bit 31 follow the monitor width control.
// - Host mode with general trap makes bit 31 act as one.
// - Bit 30 traps unsecured kernel reads of memory control registers.
// - Bit 29 makes hypercall undefined; exists only without a monitor level.
// - Bit 28 traps 64-bit zero-block op and hides it from the info register.
// - Host mode with general trap makes the zero-block trap act as zero.
// - General trap routes kernel exceptions up, disables kernel translation, virtual interrupts.
// - General trap makes kernel exception return illegal and disables other virtual signalling.
// - General trap without host mode forces interrupt routing and debug traps to one.
// - General trap is never cached; its effect follows the stored bit at once.
// - Bit 26 traps unsecured kernel writes of memory control registers.
// - Bits 37:36 read zero; earlier revision also zeroes bits 35 and 34.
// - Without hypervisor level the whole register reads zero.
module hcu_hyp_config #(
    parameter bit HAS_HYP = 1'b1,
    parameter bit HAS_MONITOR = 1'b1,
    parameter bit REV_81 = 1'b1,
    parameter bit MIOC_IMPL = 1'b1,
    parameter bit LOWER_AA32_OK = 1'b1
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [3:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Processor context, same clock
    input wire logic [1:0] i_cur_level,
    input wire logic i_cur_is64,
    input wire logic i_app_level_state_bit,
    input wire logic i_regime_lower,
    input wire logic i_ordering_region_acc,
    input wire logic i_memctl_rd,
    input wire logic i_memctl_wr,
    input wire logic i_zero_block_op,
    input wire logic i_hypercall,
    input wire logic i_eret_to_kernel,
    // Effective controls
    output logic [10:0] o_eff,
    output logic o_mismatch_noncoherent,
    output logic o_s2_instr_nocache,
    output logic o_s2_data_nocache,
    output logic o_kernel_is64,
    output logic o_app_is64,
    output logic o_trap_ordering_region,
    output logic o_trap_memctl_rd,
    output logic o_trap_memctl_wr,
    output logic o_trap_zero_block,
    output logic o_zero_block_unsupported,
    output logic o_hypercall_undef,
    output logic o_route_kernel_to_hyp,
    output logic o_kernel_xlat_off,
    output logic o_virq_disable,
    output logic o_illegal_eret,
    output logic [2:0] o_force_phys_route,
    output logic [2:0] o_force_debug_trap
);
    import hcu_pkg::*;

    // Stored fields, bits 38..26 packed as cfg[i-26]
    logic [12:0] cfg;
    logic [2:0] ctx;
    logic [63:0] reg_view;
    logic [10:0] eff;
    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic world;
    logic e2h_eff;
    logic tge_eff;
    logic host;

    // Only the four words are mapped; all else answers with an error
    assign addr_ok = (i_paddr == HCU_OFF_CFG_LO) || (i_paddr == HCU_OFF_CFG_HI) ||
                     (i_paddr == HCU_OFF_CTX) || (i_paddr == HCU_OFF_EFF);
    assign wr_en = i_psel && i_penable && i_pwrite && addr_ok;
    assign rd_setup = i_psel && !i_penable && !i_pwrite;
    // Zero wait states keep the core's system instruction path short
    assign o_pready = 1'b1;
    // Unmapped words answer with an error so a bad offset is never silent
    assign o_pslverr = i_psel && i_penable && !addr_ok;

    // Direct read view with reserved and absent fields forced
    always_comb begin
        reg_view = 64'h0;
        reg_view[HCU_B_TVM +: 13] = cfg;
        reg_view[37:36] = 2'h0;
        if (!REV_81) begin
            reg_view[HCU_B_ORDERING_REGION_TRAP] = 1'b0;
            reg_view[HCU_B_E2H] = 1'b0;
        end
        if (!MIOC_IMPL) begin
            reg_view[HCU_B_MIOC] = 1'b0;
        end
        if (HAS_MONITOR) begin
            reg_view[HCU_B_HCD] = 1'b0;
        end
        if (!LOWER_AA32_OK) begin
            reg_view[HCU_B_RW] = 1'b1;
        end
        if (!HAS_HYP) begin
            reg_view = 64'h0;
        end
    end

    // Configuration store; writes to absent hypervisor level are ignored
    // The two halves are independent; software may write them in any order
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cfg <= HCU_CFG_RESET;
        end else if (wr_en && HAS_HYP) begin
            if (i_paddr == HCU_OFF_CFG_LO) begin
                cfg[5:0] <= i_pwdata[31:26];
            end else if (i_paddr == HCU_OFF_CFG_HI) begin
                cfg[12:6] <= i_pwdata[6:0];
            end
        end
    end

    // Context register: world select, monitor width, stage 2 enable
    // Stands in for the monitor's own controls, which live outside this bank
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctx <= HCU_CTX_RESET;
        end else if (wr_en && i_paddr == HCU_OFF_CTX) begin
            ctx <= i_pwdata[2:0];
        end
    end

    // Read data captured in the setup cycle, valid through the access phase
    // Capturing early costs 32 flops but gives a full cycle of settled data
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_prdata <= 32'h0;
        end else if (rd_setup) begin
            unique case (i_paddr)
                HCU_OFF_CFG_LO: o_prdata <= reg_view[31:0];
                HCU_OFF_CFG_HI: o_prdata <= reg_view[63:32];
                HCU_OFF_CTX: o_prdata <= {29'h0, ctx};
                HCU_OFF_EFF: o_prdata <= {21'h0, eff};
                default: o_prdata <= 32'h0;
            endcase
        end
    end

    // Without a monitor level the world is always unsecured
    assign world = HAS_MONITOR ? ctx[HCU_C_WORLD] : 1'b1;
    assign e2h_eff = world && reg_view[HCU_B_E2H];
    // Read straight from the store so a change acts at once, never cached
    assign tge_eff = world && reg_view[HCU_B_TGE];
    assign host = e2h_eff && tge_eff;

    // Effective values of each field
    // Host mode needs both bits live, so it never counts in the secure world
    always_comb begin
        eff = 11'h0;
        eff[HCU_E_MIOC] = world && reg_view[HCU_B_MIOC] && !host;
        eff[HCU_E_ORDERING_REGION_TRAP] = world && reg_view[HCU_B_ORDERING_REGION_TRAP] && !tge_eff;
        eff[HCU_E_E2H] = e2h_eff;
        eff[HCU_E_ID] = world && reg_view[HCU_B_ID] && !host;
        eff[HCU_E_CD] = world && reg_view[HCU_B_CD] && !host;
        if (host) begin
            eff[HCU_E_RW] = 1'b1;
        end else if (!world) begin
            eff[HCU_E_RW] = ctx[HCU_C_MONW];
        end else begin
            eff[HCU_E_RW] = reg_view[HCU_B_RW];
        end
        eff[HCU_E_MEMCTL_READ_TRAP] = world && reg_view[HCU_B_MEMCTL_READ_TRAP] && !tge_eff;
        eff[HCU_E_HCD] = reg_view[HCU_B_HCD] && !tge_eff;
        eff[HCU_E_TDZ] = world && reg_view[HCU_B_TDZ] && !host;
        eff[HCU_E_TGE] = tge_eff;
        eff[HCU_E_TVM] = world && reg_view[HCU_B_TVM] && !tge_eff;
    end

    assign o_eff = eff;

    // Stage 2 attribute overrides, lower regime only
    assign o_mismatch_noncoherent = eff[HCU_E_MIOC] && i_regime_lower;
    assign o_s2_instr_nocache = eff[HCU_E_ID] && ctx[HCU_C_S2EN] && i_regime_lower;
    assign o_s2_data_nocache = eff[HCU_E_CD] && ctx[HCU_C_S2EN] && i_regime_lower;

    // Execution state of lower levels; app state bit high means 32-bit
    assign o_kernel_is64 = eff[HCU_E_RW];
    assign o_app_is64 = eff[HCU_E_RW] && !i_app_level_state_bit;

    // Trap decisions for the current access
    assign o_trap_ordering_region = i_ordering_region_acc && world &&
                                    (i_cur_level == HCU_LVL_KERNEL) && eff[HCU_E_ORDERING_REGION_TRAP];
    assign o_trap_memctl_rd = i_memctl_rd && world &&
                              (i_cur_level == HCU_LVL_KERNEL) && eff[HCU_E_MEMCTL_READ_TRAP];
    assign o_trap_memctl_wr = i_memctl_wr && world &&
                              (i_cur_level == HCU_LVL_KERNEL) && eff[HCU_E_TVM];
    assign o_trap_zero_block = i_zero_block_op && i_cur_is64 && world &&
                               ((i_cur_level == HCU_LVL_APP) || (i_cur_level == HCU_LVL_KERNEL)) &&
                               eff[HCU_E_TDZ];
    assign o_zero_block_unsupported = eff[HCU_E_TDZ];
    // Exception for an undefined hypercall goes to the level that executed it
    assign o_hypercall_undef = i_hypercall && eff[HCU_E_HCD] &&
                               ((i_cur_level == HCU_LVL_HYP) ||
                                (i_cur_level == HCU_LVL_KERNEL && world));

    // General trap consequences
    // With host mode the routing fields stay as software wrote them
    assign o_route_kernel_to_hyp = tge_eff;
    assign o_kernel_xlat_off = tge_eff;
    assign o_virq_disable = tge_eff;
    assign o_illegal_eret = i_eret_to_kernel && tge_eff;
    assign o_force_phys_route = {3{tge_eff && !e2h_eff}};
    assign o_force_debug_trap = {3{tge_eff && !e2h_eff}};

    // Assertions
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    // One access phase of a write and one setup phase of a read
    sequence s_write_hi;
        i_psel && i_penable && i_pwrite && i_paddr == HCU_OFF_CFG_HI;
    endsequence

    sequence s_read_hi;
        i_psel && !i_penable && !i_pwrite && i_paddr == HCU_OFF_CFG_HI;
    endsequence

    sequence s_write_lo;
        i_psel && i_penable && i_pwrite && i_paddr == HCU_OFF_CFG_LO;
    endsequence

    a_secure_zero: assert property (!world |-> !eff[HCU_E_MIOC] && !eff[HCU_E_TDZ] &&
                                    !eff[HCU_E_TVM] && !eff[HCU_E_E2H])
        else $error("secure world left a control active");
    a_host_nocache: assert property (host |-> !o_s2_instr_nocache && !o_s2_data_nocache &&
                                     !o_mismatch_noncoherent)
        else $error("host mode kept a no-cache override");
    a_tge_ignores: assert property (tge_eff |-> !o_trap_ordering_region && !o_trap_memctl_rd &&
                                    !o_hypercall_undef)
        else $error("general trap did not mask traps");
    a_s2_regime: assert property (!i_regime_lower |->
                                  !o_s2_instr_nocache && !o_s2_data_nocache)
        else $error("stage 2 override reached upper regime");
    a_rw_host: assert property (host |-> o_kernel_is64)
        else $error("host mode lower state not 64-bit");
    a_rw_secure: assert property (!world |-> o_kernel_is64 == ctx[HCU_C_MONW])
        else $error("secure lower state ignores monitor width");
    a_reserved_zero: assert property (s_read_hi ##1 i_penable |-> o_prdata[5:4] == 2'h0)
        else $error("reserved bits 37:36 read non-zero");
    a_write_hi: assert property (s_write_hi |=>
                                 e2h_eff == (HAS_HYP && REV_81 && world &&
                                             $past(i_pwdata[HCU_B_E2H - 32])))
        else $error("high word write not reflected");
    a_phys_force: assert property (tge_eff && !e2h_eff |-> o_force_phys_route == 3'h7 &&
                                   o_force_debug_trap == 3'h7)
        else $error("routing fields not forced");
    a_tdz_trap: assert property (i_zero_block_op && i_cur_is64 && world &&
                                 i_cur_level == HCU_LVL_KERNEL && eff[HCU_E_TDZ]
                                 |-> o_trap_zero_block)
        else $error("zero-block op not trapped");

    // Writes must act on the next cycle; nothing in between may hold an old copy
    a_write_lo: assert property (s_write_lo |=>
                                 tge_eff == (HAS_HYP && world && $past(i_pwdata[HCU_B_TGE])))
        else $error("low word write not reflected");

    // Trap decisions follow their event inputs in the same cycle
    a_order_trap: assert property (eff[HCU_E_ORDERING_REGION_TRAP] && i_cur_level == HCU_LVL_KERNEL |->
                                   o_trap_ordering_region == i_ordering_region_acc)
        else $error("ordering region access not trapped");
    a_memrd_trap: assert property (eff[HCU_E_MEMCTL_READ_TRAP] && i_cur_level == HCU_LVL_KERNEL |->
                                   o_trap_memctl_rd == i_memctl_rd)
        else $error("memory control read not trapped");
    a_memwr_trap: assert property (eff[HCU_E_TVM] && i_cur_level == HCU_LVL_KERNEL |->
                                   o_trap_memctl_wr == i_memctl_wr)
        else $error("memory control write not trapped");
    a_upper_notrap: assert property (i_cur_level != HCU_LVL_KERNEL |->
                                     !o_trap_ordering_region && !o_trap_memctl_rd &&
                                     !o_trap_memctl_wr)
        else $error("register trap raised outside kernel level");
    a_hcd_undef: assert property (eff[HCU_E_HCD] && i_hypercall &&
                                  i_cur_level == HCU_LVL_HYP |-> o_hypercall_undef)
        else $error("disabled hypercall not made undefined");
    a_hcd_absent: assert property (eff[HCU_E_HCD] |-> !HAS_MONITOR)
        else $error("hypercall disable active with a monitor level");

    // Lower level execution state
    a_app_state: assert property (eff[HCU_E_RW] |->
                                  o_kernel_is64 && o_app_is64 == !i_app_level_state_bit)
        else $error("lower level state wrong for 64-bit kernel");
    a_lower32: assert property (!eff[HCU_E_RW] |-> !o_kernel_is64 && !o_app_is64)
        else $error("lower levels not 32-bit");

    // Stage 2 and coherency overrides
    a_s2_instr: assert property (eff[HCU_E_ID] && ctx[HCU_C_S2EN] && i_regime_lower |->
                                 o_s2_instr_nocache)
        else $error("instruction stage 2 not forced non-cacheable");
    a_s2_data: assert property (eff[HCU_E_CD] && ctx[HCU_C_S2EN] && i_regime_lower |->
                                o_s2_data_nocache)
        else $error("data stage 2 not forced non-cacheable");
    a_s2_off: assert property (!ctx[HCU_C_S2EN] |->
                               !o_s2_instr_nocache && !o_s2_data_nocache)
        else $error("stage 2 override with stage 2 off");
    a_mioc_impl: assert property (eff[HCU_E_MIOC] |-> MIOC_IMPL && HAS_HYP)
        else $error("mismatch control active where not built");

    // General trap consequences and host mode masking
    a_tge_route: assert property (tge_eff |->
                                  o_route_kernel_to_hyp && o_kernel_xlat_off && o_virq_disable)
        else $error("general trap consequences missing");
    a_eret_illegal: assert property (tge_eff && i_eret_to_kernel |-> o_illegal_eret)
        else $error("kernel exception return not illegal");
    a_tdz_host: assert property (host |->
                                 !o_trap_zero_block && !o_zero_block_unsupported)
        else $error("zero-block trap active in host mode");

    // Build options that hide fields from the direct view
    a_old_rev: assert property (e2h_eff || eff[HCU_E_ORDERING_REGION_TRAP] |-> REV_81)
        else $error("newer fields active in earlier revision");
    a_no_hyp: assert property (s_read_hi ##1 i_penable |-> HAS_HYP || o_prdata == 32'h0)
        else $error("absent hypervisor level read non-zero");

    // A bank that no level can reach is refused when the design is built
    if (!HAS_HYP && !HAS_MONITOR) begin : g_bad_params
        $error("neither hypervisor nor monitor level can reach this bank");
    end
endmodule // hcu_hyp_config

`default_nettype wire

// ===== hcu_pkg.sv
// Package with offsets, field positions and reset values of the hypervisor configuration bank
package hcu_pkg;
    // Word offsets on the register bus (byte addresses)
    localparam logic [3:0] HCU_OFF_CFG_LO = 4'h0; // hyp_config_reg bits 31:0
    localparam logic [3:0] HCU_OFF_CFG_HI = 4'h4; // hyp_config_reg bits 63:32
    localparam logic [3:0] HCU_OFF_CTX = 4'h8;    // Security context and stage 2 enable
    localparam logic [3:0] HCU_OFF_EFF = 4'hc;    // Effective control values, read only
    // Field positions inside the 64-bit register
    localparam int HCU_B_MIOC = 38;
    localparam int HCU_B_ORDERING_REGION_TRAP = 35;
    localparam int HCU_B_E2H = 34;
    localparam int HCU_B_ID = 33;
    localparam int HCU_B_CD = 32;
    localparam int HCU_B_RW = 31;
    localparam int HCU_B_MEMCTL_READ_TRAP = 30;
    localparam int HCU_B_HCD = 29;
    localparam int HCU_B_TDZ = 28;
    localparam int HCU_B_TGE = 27;
    localparam int HCU_B_TVM = 26;
    // Field positions inside the context register
    localparam int HCU_C_WORLD = 0;
    localparam int HCU_C_MONW = 1;
    localparam int HCU_C_S2EN = 2;
    // Field positions inside the effective value register
    localparam int HCU_E_MIOC = 0;
    localparam int HCU_E_ORDERING_REGION_TRAP = 1;
    localparam int HCU_E_E2H = 2;
    localparam int HCU_E_ID = 3;
    localparam int HCU_E_CD = 4;
    localparam int HCU_E_RW = 5;
    localparam int HCU_E_MEMCTL_READ_TRAP = 6;
    localparam int HCU_E_HCD = 7;
    localparam int HCU_E_TDZ = 8;
    localparam int HCU_E_TGE = 9;
    localparam int HCU_E_TVM = 10;
    // Reset values; the stored fields have no defined value, zero is chosen
    localparam logic [12:0] HCU_CFG_RESET = 13'h0000;
    localparam logic [2:0] HCU_CTX_RESET = 3'h1;
    // Exception level encodings
    localparam logic [1:0] HCU_LVL_APP = 2'h0;
    localparam logic [1:0] HCU_LVL_KERNEL = 2'h1;
    localparam logic [1:0] HCU_LVL_HYP = 2'h2;
    localparam logic [1:0] HCU_LVL_MONITOR = 2'h3;
endpackage

// ===== tb_top.sv
// Self-checking bench for the hypervisor configuration bank over APB
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import hcu_pkg::*;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [3:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] lvl;
    logic is64, appst, lower, ora, mrd, mwr, zbo, hypercall, eret;
    logic [10:0] eff;
    logic mnc, s2i, s2d, k64, a64, t_or, t_rd, t_wr, t_zb, zb_uns, hv_ud, route, xoff, vdis, ieret;
    logic [2:0] fphys, fdbg;
    logic [31:0] prdata_b, rd_b;
    logic hv_ud_b;
    int n_fail, cmp_count;

    hcu_hyp_config dut_u (.i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_cur_level(lvl), .i_cur_is64(is64),
        .i_app_level_state_bit(appst), .i_regime_lower(lower), .i_ordering_region_acc(ora),
        .i_memctl_rd(mrd), .i_memctl_wr(mwr), .i_zero_block_op(zbo), .i_hypercall(hypercall),
        .i_eret_to_kernel(eret), .o_eff(eff), .o_mismatch_noncoherent(mnc),
        .o_s2_instr_nocache(s2i), .o_s2_data_nocache(s2d), .o_kernel_is64(k64),
        .o_app_is64(a64), .o_trap_ordering_region(t_or), .o_trap_memctl_rd(t_rd),
        .o_trap_memctl_wr(t_wr), .o_trap_zero_block(t_zb), .o_zero_block_unsupported(zb_uns),
        .o_hypercall_undef(hv_ud), .o_route_kernel_to_hyp(route), .o_kernel_xlat_off(xoff),
        .o_virq_disable(vdis), .o_illegal_eret(ieret), .o_force_phys_route(fphys),
        .o_force_debug_trap(fdbg));

    // Second build: no monitor level, earlier revision, fixed 64-bit lower levels
    hcu_hyp_config #(.HAS_HYP(1'b1), .HAS_MONITOR(1'b0), .REV_81(1'b0), .MIOC_IMPL(1'b0),
        .LOWER_AA32_OK(1'b0)) dut_u_nomon (.i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata_b), .o_pready(), .o_pslverr(), .i_cur_level(lvl), .i_cur_is64(is64),
        .i_app_level_state_bit(appst), .i_regime_lower(lower), .i_ordering_region_acc(ora),
        .i_memctl_rd(mrd), .i_memctl_wr(mwr), .i_zero_block_op(zbo), .i_hypercall(hypercall),
        .i_eret_to_kernel(eret), .o_eff(), .o_mismatch_noncoherent(),
        .o_s2_instr_nocache(), .o_s2_data_nocache(), .o_kernel_is64(), .o_app_is64(),
        .o_trap_ordering_region(), .o_trap_memctl_rd(), .o_trap_memctl_wr(),
        .o_trap_zero_block(), .o_zero_block_unsupported(), .o_hypercall_undef(hv_ud_b),
        .o_route_kernel_to_hyp(), .o_kernel_xlat_off(), .o_virq_disable(), .o_illegal_eret(),
        .o_force_phys_route(), .o_force_debug_trap());

    // Free-running 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; an edge always passes first so psel is never set twice in a step
    task automatic apb(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            final_report();
        end
        rd = prdata;
        rd_b = prdata_b;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Present one core-side access, then let it settle before looking
    task automatic core(input logic [1:0] l, input logic lw, input logic [5:0] ev);
        @(posedge clk);
        lvl <= l;
        lower <= lw;
        {ora, mrd, mwr, zbo, hypercall, eret} <= ev;
        @(posedge clk);
        #1;
    endtask

    initial begin
        n_fail = 0;
        cmp_count = 0;
        {nrst, psel, penable, pwrite, ora, mrd, mwr, zbo, hypercall, eret, appst} = '0;
        paddr = 4'h0;
        pwdata = 32'h0;
        lvl = HCU_LVL_APP;
        is64 = 1'b1;
        lower = 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        // Reset values and reserved bits
        apb(HCU_OFF_CFG_LO, 1'b0, 32'h0); chk(rd, 32'h0);
        chk(rd_b, 32'h80000000);
        apb(HCU_OFF_CTX, 1'b0, 32'h0); chk(rd, 32'(HCU_CTX_RESET));
        apb(HCU_OFF_CFG_LO, 1'b1, 32'hf4000000);
        apb(HCU_OFF_CFG_HI, 1'b1, 32'h0000007f);
        apb(HCU_OFF_CFG_LO, 1'b0, 32'h0); chk(rd, 32'hd4000000);
        chk(rd_b, 32'hf4000000);
        apb(HCU_OFF_CFG_HI, 1'b0, 32'h0); chk(rd, 32'h0000004f);
        chk(rd_b, 32'h00000003);
        $display("test reserved done");
        // Unsecured, bit 34 set but no general trap so not host mode: every field the build keeps is live
        apb(HCU_OFF_CTX, 1'b1, 32'h5);
        apb(HCU_OFF_EFF, 1'b0, 32'h0); chk(rd, 32'h57f);
        chk(rd_b, 32'h5f8);
        core(HCU_LVL_KERNEL, 1'b1, 6'b111100);
        chk(32'(eff), 32'h57f);
        chk(32'({t_or, t_rd, t_wr, t_zb}), 32'hf);
        chk(32'({zb_uns, s2i, s2d, mnc}), 32'hf);
        core(HCU_LVL_HYP, 1'b0, 6'b000010);
        chk(32'({s2i, s2d}), 32'h0);
        chk(32'({hv_ud, hv_ud_b}), 32'h1);
        apb(HCU_OFF_EFF, 1'b1, 32'h0);
        apb(HCU_OFF_EFF, 1'b0, 32'h0); chk(rd, 32'h57f);
        apb(4'h2, 1'b1, 32'hffffffff); chk(32'(err), 32'h1);
        apb(4'h2, 1'b0, 32'h0); chk(rd, 32'h0);
        $display("test live controls done");
        // Secure world: all act as zero, width follows the monitor
        apb(HCU_OFF_CTX, 1'b1, 32'h6);
        #1;
        chk(32'(eff), 32'h020);
        apb(HCU_OFF_CFG_LO, 1'b0, 32'h0); chk(rd, 32'hd4000000);
        $display("test secure world done");
        // Host mode with general trap
        apb(HCU_OFF_CTX, 1'b1, 32'h5);
        apb(HCU_OFF_CFG_LO, 1'b1, 32'hdc000000);
        #1;
        chk(32'(eff), 32'h224);
        chk(32'(fphys), 32'h0);
        $display("test host trap done");
        // General trap without host mode
        apb(HCU_OFF_CFG_HI, 1'b1, 32'h0000004b);
        core(HCU_LVL_KERNEL, 1'b1, 6'b000001);
        chk(32'(eff), 32'h339);
        chk(32'({fphys, fdbg}), 32'h3f);
        chk(32'({route, xoff, vdis}), 32'h7);
        chk(32'(ieret), 32'h1);
        // 32-bit current state escapes the zero-block trap; app level follows its state bit
        @(posedge clk);
        is64 <= 1'b0;
        appst <= 1'b1;
        core(HCU_LVL_KERNEL, 1'b1, 6'b000100);
        chk(32'({t_zb, zb_uns, k64, a64}), 32'h6);
        // Dropping the trap must act at once, nothing cached
        apb(HCU_OFF_CFG_LO, 1'b1, 32'hd4000000);
        #1;
        chk(32'({route, ieret, fphys}), 32'h0);
        $display("test general trap done");
        // Mid-run reset brings the stored fields and the context back
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        apb(HCU_OFF_CFG_HI, 1'b0, 32'h0); chk(rd, 32'h0);
        chk(rd_b, 32'h0);
        chk(32'(eff), 32'h0);
        apb(HCU_OFF_CTX, 1'b0, 32'h0); chk(rd, 32'(HCU_CTX_RESET));
        $display("test mid-run reset done");
        final_report();
    end
endmodule // tb_top

`default_nettype wire
